// file: hdl/glyph_pkg.sv
package glyph_pkg;
  localparam int addr_width = 16;
  localparam int byte_width = 8;
  localparam logic [15:0] glyph_table_base = 16'h0400;
  localparam int columns_per_glyph = 5;
  localparam logic [7:0] glyph_stride = 8'h05;
  localparam logic [7:0] last_glyph_index = 8'h11;
  localparam int lit_rows = 7;
  localparam int fifo_depth = 16;
  localparam int fetch_latency = 1;
  localparam real clock_period_ns = 25.0;
  localparam real min_half_bit_ns = 25.0;
  localparam int half_bit_cycles = int'($ceil(min_half_bit_ns / clock_period_ns));
  localparam logic [3:0] low_digit_limit = 4'h7;
endpackage

// file: hdl/column_fifo.sv
`timescale 1ns/1ps
module column_fifo #(
  parameter int width = 8,
  parameter int depth = 16
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [width-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [width-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int aw = $clog2(depth);
  // Pointer wrap logic only works for a power-of-two depth
  if (depth < 2 || (1 << aw) != depth) begin : g_bad_depth
    $error("depth must be a power of two, at least 2");
  end
  logic [width-1:0] mem [depth];
  logic [aw:0] wr_ptr;
  logic [aw:0] rd_ptr;
  logic push;
  logic pop;
  // Full when pointers differ only in the wrap bit
  assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {aw{1'b0}}};
  assign out_valid = wr_ptr != rd_ptr;
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_data = mem[rd_ptr[aw-1:0]];
  always_ff @(posedge mclk) begin
    if (push) begin
      mem[wr_ptr[aw-1:0]] <= in_data;
    end
  end
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (aw+1)'(push);
      rd_ptr <= rd_ptr + (aw+1)'(pop);
    end
  end
endmodule

// file: hdl/glyph_column_serializer.sv
`timescale 1ns/1ps
module glyph_column_serializer #(
  parameter logic [15:0] table_base = glyph_pkg::glyph_table_base,
  parameter logic [7:0] last_index = glyph_pkg::last_glyph_index,
  parameter int depth = glyph_pkg::fifo_depth
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  output logic [glyph_pkg::addr_width-1:0] table_addr,
  output logic table_read,
  input wire logic [glyph_pkg::byte_width-1:0] table_data,
  output logic disp_data,
  output logic disp_clk,
  output logic disp_load,
  output logic busy,
  output logic digit_error
);
  import glyph_pkg::*;

  // Refuse a one-glyph index range (last_index zero) and a table that would wrap the 16-bit address space
  if (last_index == 8'h00) begin : g_bad_index
    $error("last_index must be nonzero");
  end
  if (32'(table_base) + 32'(last_index) * 32'(columns_per_glyph) + 32'(columns_per_glyph) > 32'h0001_0000) begin : g_bad_span
    $error("glyph table would run past the end of the address space");
  end

  // Fetch and shift run as two machines joined by the column FIFO
  typedef enum logic [1:0] {f_idle, f_issue, f_wait, f_push} fetch_t;
  typedef enum logic [2:0] {s_idle, s_load, s_setup, s_high, s_low, s_latch} shift_t;

  // Machine state, address arithmetic, FIFO handshake and shifter
  fetch_t fetch_state;
  shift_t shift_state;
  logic [7:0] glyph_index_counter;
  logic [2:0] column;
  logic [15:0] table_base_pointer;
  logic [7:0] fetched;
  logic [7:0] fifo_in;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [7:0] fifo_out;
  logic fifo_out_valid;
  logic fifo_pop;
  logic [7:0] shreg;
  logic [2:0] bit_cnt;
  logic [7:0] half_cnt;
  logic [15:0] product;
  logic [8:0] low_sum;
  logic [7:0] table_pointer_low;
  logic [7:0] table_pointer_high;
  logic [15:0] glyph_addr;
  logic fetch_done;
  logic index_done;

  // Offset = index * 5, summed bytewise with carry as the table pointer was
  assign product = {8'h00, glyph_index_counter} * {8'h00, glyph_stride};
  assign low_sum = {1'b0, table_base_pointer[7:0]} + {1'b0, product[7:0]};
  assign table_pointer_low = low_sum[7:0];
  assign table_pointer_high = table_base_pointer[15:8] + product[15:8] + {7'h00, low_sum[8]};
  assign glyph_addr = {table_pointer_high, table_pointer_low};
  assign index_done = glyph_index_counter == last_index;

  // Fetch side: one byte per column, five per glyph
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      fetch_state <= f_idle;
      glyph_index_counter <= 8'h00;
      column <= 3'h0;
      table_base_pointer <= 16'h0000;
      table_addr <= 16'h0000;
      table_read <= 1'b0;
      fetched <= 8'h00;
      fetch_done <= 1'b0;
    end else begin
      table_read <= 1'b0;
      case (fetch_state)
        f_idle: begin
          if (start && !busy) begin
            table_base_pointer <= table_base;
            glyph_index_counter <= 8'h00;
            column <= 3'h0;
            fetch_done <= 1'b0;
            fetch_state <= f_issue;
          end
        end
        f_issue: begin
          table_addr <= glyph_addr + {13'h0000, column};
          table_read <= 1'b1;
          fetch_state <= f_wait;
        end
        f_wait: begin
          fetched <= table_data; // Synchronous table: data one cycle after read
          fetch_state <= f_push;
        end
        f_push: begin
          // Back-pressure: hold here while the FIFO is full
          if (fifo_in_ready) begin
            if (column == 3'(columns_per_glyph - 1)) begin
              column <= 3'h0;
              if (index_done) begin
                fetch_done <= 1'b1;
                fetch_state <= f_idle;
              end else begin
                glyph_index_counter <= glyph_index_counter + 8'h01;
                fetch_state <= f_issue;
              end
            end else begin
              column <= column + 3'h1;
              fetch_state <= f_issue;
            end
          end
        end
        default: fetch_state <= f_idle;
      endcase
    end
  end

  // Push from the fetch side, pop only when the shifter takes a new byte
  assign fifo_in = fetched;
  assign fifo_in_valid = fetch_state == f_push;
  assign fifo_pop = shift_state == s_load && fifo_out_valid;

  // Buffer lets fetching run ahead of the much slower serial side
  column_fifo #(.width(byte_width), .depth(depth)) u_fifo (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .in_data(fifo_in),
    .in_valid(fifo_in_valid),
    .in_ready(fifo_in_ready),
    .out_data(fifo_out),
    .out_valid(fifo_out_valid),
    .out_ready(fifo_pop)
  );

  // Shift side: eight bits per column, load strobe after each column
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      shift_state <= s_idle;
      shreg <= 8'h00;
      bit_cnt <= 3'h0;
      half_cnt <= 8'h00;
      disp_data <= 1'b0;
      disp_clk <= 1'b0;
      disp_load <= 1'b0;
      busy <= 1'b0;
      digit_error <= 1'b0;
    end else begin
      case (shift_state)
        s_idle: begin
          disp_clk <= 1'b0;
          if (start && !busy) begin
            busy <= 1'b1;
            digit_error <= 1'b0;
            shift_state <= s_load;
          end
        end
        s_load: begin
          disp_load <= 1'b0;
          if (fifo_out_valid) begin
            shreg <= fifo_out; // dot value passed unchanged
            // Flag a first digit above seven; byte still sent as stored
            if (fifo_out[7:4] > low_digit_limit) digit_error <= 1'b1;
            bit_cnt <= 3'h7;
            shift_state <= s_setup;
          end else if (fetch_done) begin
            busy <= 1'b0;
            shift_state <= s_idle;
          end
        end
        s_setup: begin
          disp_data <= shreg[7];
          half_cnt <= 8'(half_bit_cycles);
          shift_state <= s_high;
        end
        s_high: begin
          if (half_cnt > 8'h01) begin
            half_cnt <= half_cnt - 8'h01;
          end else begin
            disp_clk <= 1'b1;
            half_cnt <= 8'(half_bit_cycles);
            shift_state <= s_low;
          end
        end
        s_low: begin
          if (half_cnt > 8'h01) begin
            half_cnt <= half_cnt - 8'h01;
          end else begin
            disp_clk <= 1'b0;
            shreg <= {shreg[6:0], 1'b0};
            if (bit_cnt == 3'h0) begin
              shift_state <= s_latch;
            end else begin
              bit_cnt <= bit_cnt - 3'h1;
              shift_state <= s_setup;
            end
          end
        end
        s_latch: begin
          // Clock already low here, so the strobe latches without a stray shift
          disp_load <= 1'b1;
          shift_state <= s_load;
        end
        default: shift_state <= s_idle;
      endcase
    end
  end
endmodule

// file: verification/serializer_checker_assertions.sv
`timescale 1ns/1ps
module serializer_checker #(
  parameter logic [15:0] table_base = 16'h0400,
  parameter logic [7:0] last_index = 8'h11
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic [15:0] table_addr,
  input wire logic table_read,
  input wire logic [7:0] table_data,
  input wire logic disp_data,
  input wire logic disp_clk,
  input wire logic disp_load,
  input wire logic busy,
  input wire logic digit_error
);
  localparam logic [15:0] span = (16'(last_index) + 16'h0001) * 16'h0005;
  logic [15:0] prev_addr;
  logic seen;
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Previous fetch address within one run, forgotten when idle
  always_ff @(posedge mclk) begin
    if (sys_rst || !busy) seen <= 1'b0;
    else if (table_read) seen <= 1'b1;
  end
  always_ff @(posedge mclk) begin
    if (table_read) prev_addr <= table_addr;
  end
  sequence s_launch; start && !busy; endsequence
  sequence s_pulse; disp_clk ##1 !disp_clk; endsequence
  sequence s_load; !disp_clk && disp_load ##1 !disp_load; endsequence
  property p_busy; s_launch |=> busy; endproperty
  a_busy: assert property (p_busy) else $error("busy did not follow start");
  property p_read; s_launch |-> ##2 table_read; endproperty
  a_read: assert property (p_read) else $error("no fetch two cycles after start");
  property p_base; s_launch |-> ##2 table_addr == table_base; endproperty
  a_base: assert property (p_base) else $error("first fetch not at table base");
  property p_range; table_read |-> (table_addr - table_base) < span; endproperty
  a_range: assert property (p_range) else $error("fetch outside glyph table");
  property p_step; table_read && seen |-> table_addr == prev_addr + 16'h0001; endproperty
  a_step: assert property (p_step) else $error("fetch address skipped");
  property p_clk; $rose(disp_clk) |-> $stable(disp_data) ##0 s_pulse; endproperty
  a_clk: assert property (p_clk) else $error("shift clock pulse malformed");
  property p_load; disp_load |-> s_load; endproperty
  a_load: assert property (p_load) else $error("load strobe malformed");
  property p_idle; !busy |-> !table_read && !disp_clk; endproperty
  a_idle: assert property (p_idle) else $error("activity while idle");
endmodule

bind glyph_column_serializer serializer_checker #(.table_base(table_base), .last_index(last_index)) chk_u (
  .mclk(mclk), .sys_rst(sys_rst), .start(start), .table_addr(table_addr), .table_read(table_read),
  .table_data(table_data), .disp_data(disp_data), .disp_clk(disp_clk), .disp_load(disp_load),
  .busy(busy), .digit_error(digit_error));

// file: verification/display_model.sv
`timescale 1ns/1ps
module display_model (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic disp_data,
  input wire logic disp_clk,
  input wire logic disp_load,
  output logic [7:0] dots,
  output logic [7:0] nbits
);
  logic clk_prev;
  // Shift on the clock's rise; bits kept as sent, a one being a lit dot
  always_ff @(posedge mclk) begin
    clk_prev <= disp_clk;
    if (sys_rst || disp_load) nbits <= 8'h00;
    else if (disp_clk && !clk_prev) nbits <= nbits + 8'h01;
    if (disp_clk && !clk_prev) dots <= {dots[6:0], disp_data};
  end
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import glyph_pkg::*;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic start = 1'b0;
  logic bad = 1'b0;
  logic [7:0] table_data = 8'h00;
  logic [7:0] dots, nbits;
  logic [15:0] table_addr;
  logic table_read, disp_data, disp_clk, disp_load, busy, digit_error;
  int fails = 0;
  int n_tests = 0;
  int loads = 0;
  glyph_column_serializer dut_u (.mclk(mclk), .sys_rst(sys_rst), .start(start), .table_addr(table_addr),
    .table_read(table_read), .table_data(table_data), .disp_data(disp_data), .disp_clk(disp_clk),
    .disp_load(disp_load), .busy(busy), .digit_error(digit_error));
  display_model model_u (.mclk(mclk), .sys_rst(sys_rst), .disp_data(disp_data), .disp_clk(disp_clk),
    .disp_load(disp_load), .dots(dots), .nbits(nbits));
  initial forever #12.5 mclk = ~mclk;
  // Asymmetric bytes so a reversed bit order shows; one first digit above seven on demand
  function automatic logic [7:0] rom(logic [15:0] a);
    return {1'b0, a[2:0] ^ 3'h5, a[3:0] ^ 4'ha} | ((bad && a == glyph_table_base + 16'h0007) ? 8'h80 : 8'h00);
  endfunction
  // Memory answers on the falling edge within the read strobe cycle
  always @(negedge mclk) if (table_read === 1'b1) table_data <= rom(table_addr);
  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // Each latched column must equal the next table byte in address order
  always @(negedge mclk) if (disp_load === 1'b1 && sys_rst === 1'b0) begin
    check("column", {8'h00, dots}, {8'h00, rom(glyph_table_base + 16'(loads))});
    check("bits", {8'h00, nbits}, 16'h0008);
    loads++;
  end
  task pulse_start;
    @(negedge mclk) start = 1'b1;
    @(negedge mclk) start = 1'b0;
  endtask
  // Bounded wait for idle; running out ends the run
  task wait_idle;
    repeat (8000) if (busy === 1'b1) @(negedge mclk);
    repeat (3) @(negedge mclk);
    check("idle", {15'h0000, busy}, 16'h0000);
    if (busy !== 1'b0) test_done;
  endtask
  // Whole table, with a second start while busy that must be ignored
  task s_full;
    loads = 0;
    pulse_start;
    repeat (200) @(negedge mclk);
    pulse_start;
    wait_idle;
    check("loads", 16'(loads), 16'(columns_per_glyph * (last_glyph_index + 1)));
    check("digit", {15'h0000, digit_error}, 16'h0000);
  endtask
  // Oversized first digit flags, and the flag clears on the next start
  task s_digit;
    bad = 1'b1;
    loads = 0;
    pulse_start;
    wait_idle;
    check("digit", {15'h0000, digit_error}, 16'h0001);
    bad = 1'b0;
    loads = 0;
    pulse_start;
    repeat (2) @(negedge mclk);
    check("digit", {15'h0000, digit_error}, 16'h0000);
    wait_idle;
  endtask
  // Reset in mid-run drops everything back to idle
  task s_reset;
    loads = 0;
    pulse_start;
    repeat (300) @(negedge mclk);
    sys_rst = 1'b1;
    @(negedge mclk) sys_rst = 1'b0;
    check("reset", {10'h000, busy, table_read, disp_clk, disp_load, digit_error, disp_data}, 16'h0000);
    check("reset addr", table_addr, 16'h0000);
  endtask
  initial begin
    repeat (10) @(negedge mclk);
    sys_rst = 1'b0;
    s_full;
    s_digit;
    s_reset;
    s_full;
    test_done;
  end
endmodule
